// ### design/cfgpm_top.sv
// Configuration pin and mode controller: reset pin, mode strap, pin directions,
// master flash read, peripheral receive, done pin and boot image select.
// Assumes all pin inputs are asynchronous to clk; pads resolve o/oe pairs.
//
// Contract
// RULE1: Low reset pin holds configuration in reset
// RULE2: Select level sampled at start picks mode
// RULE3: Select pin is input while being sampled
// RULE4: Select low gives peripheral mode, select input
// RULE5: Master mode drives select low to flash
// RULE6: Host supplies serial clock in peripheral mode
// RULE7: Master mode drives the serial clock out
// RULE8: Data pin one: peripheral input, master output
// RULE9: Data pin two: peripheral output, master input
// RULE10: Multi-image boot reads two-bit image select
// RULE11: Without multi-image boot, select pins are GPIO
// RULE12: Done pin shows configuration has completed
// RULE13: Small package may reuse done pin afterwards
// RULE14: Master waits 800/1200 us before first clock
// RULE15: Mode latched once, directions fixed until done
`timescale 1ns/1ns
module cfgpm_top #(
   parameter int LOAD_BYTES  = cfgpm_pkg::LOAD_BYTES,
   parameter bit LARGE_DENS  = 1'b0,
   parameter bit SMALL_PKG   = 1'b0,
   parameter int WAIT_SMALL  = cfgpm_pkg::WAIT_SMALL_CYC,
   parameter int WAIT_LARGE  = cfgpm_pkg::WAIT_LARGE_CYC,
   parameter int SCK_HALF    = cfgpm_pkg::SCK_HALF_CYC
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Configuration reset pin
   input  wire logic       config_reset_n,
   // Serial clock pin
   input  wire logic       sck_i,
   output logic            sck_o,
   output logic            sck_oe,
   // Serial select pin
   input  wire logic       ss_n_i,
   output logic            ss_n_o,
   output logic            ss_n_oe,
   // Serial data pin one (peripheral in, master out)
   input  wire logic       sd1_i,
   output logic            sd1_o,
   output logic            sd1_oe,
   // Serial data pin two (peripheral out, master in)
   input  wire logic       sd2_i,
   output logic            sd2_o,
   output logic            sd2_oe,
   // Boot image select pins
   input  wire logic [1:0] boot_image_select_i,
   output logic [1:0]      boot_image_select_o,
   output logic [1:0]      boot_image_select_oe,
   input  wire logic       multi_image_boot,
   // User side of the dual-use pins
   input  wire logic [1:0] user_bsel_o,
   input  wire logic [1:0] user_bsel_oe,
   output logic [1:0]      user_bsel_i,
   input  wire logic       user_done_en,
   input  wire logic       user_done_val,
   // Done pin (open drain) and status
   output logic            config_complete_o,
   output logic            config_complete_oe,
   output logic            config_complete,
   output logic            master_mode,
   // Received byte stream
   output logic            rx_valid,
   input  wire logic       rx_ready,
   output logic [7:0]      rx_data
);
   localparam int WAIT_CYC = LARGE_DENS ? WAIT_LARGE : WAIT_SMALL;
   localparam logic [cfgpm_pkg::WAIT_W-1:0] WAIT_LAST =
      cfgpm_pkg::WAIT_W'(WAIT_CYC - 1);
   localparam logic [3:0] HALF_LAST = 4'(SCK_HALF - 1);
   localparam logic [7:0] LAST_BYTE = 8'(LOAD_BYTES - 1);

   cfgpm_stream_if #(.W(8)) buf_in ();

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [cfgpm_pkg::PIN_W-1:0] pin_s1_q, pin_s2_q;
   logic                        sck_s3_q;

   // Reset to pins at rest: config reset low, select pulled high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 7'h02; // RULE1
         pin_s2_q <= 7'h02;
         sck_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= {boot_image_select_i, sd2_i, sd1_i, sck_i, ss_n_i, config_reset_n};
         pin_s2_q <= pin_s1_q;
         sck_s3_q <= pin_s2_q[cfgpm_pkg::PIN_SCK];
      end
   end

   logic       crst_s, ss_s, sck_s, sd1_s, sd2_s, sck_rise;
   logic [1:0] bsel_s;
   assign crst_s   = pin_s2_q[cfgpm_pkg::PIN_CRST];
   assign ss_s     = pin_s2_q[cfgpm_pkg::PIN_SS];
   assign sck_s    = pin_s2_q[cfgpm_pkg::PIN_SCK];
   assign sd1_s    = pin_s2_q[cfgpm_pkg::PIN_SI];
   assign sd2_s    = pin_s2_q[cfgpm_pkg::PIN_SO];
   assign bsel_s   = pin_s2_q[cfgpm_pkg::PIN_BSEL +: 2];
   assign sck_rise = sck_s && !sck_s3_q;

   // ----------------------------------------
   // Configuration sequencer state
   // ----------------------------------------
   cfgpm_pkg::cfgpm_state_type      st_q, st_d;
   cfgpm_pkg::cfgpm_mode_type       mode_q, mode_d;
   logic [cfgpm_pkg::WAIT_W-1:0]    wait_q, wait_d;
   logic [3:0]                      div_q, div_d;
   logic                            sck_q, sck_d;
   logic [cfgpm_pkg::HDR_BITS-1:0]  tx_q, tx_d;
   logic [5:0]                      bit_q, bit_d;
   logic [7:0]                      sh_q, sh_d;
   logic [7:0]                      byte_q, byte_d;
   logic                            push_q, push_d;
   logic                            master_act, edge_due, stall, got_bit, bit_in;

   // Next state, shifting and clock generation
   always_comb begin
      st_d   = st_q;
      mode_d = mode_q;
      wait_d = wait_q;
      div_d  = div_q;
      sck_d  = sck_q;
      tx_d   = tx_q;
      bit_d  = bit_q;
      sh_d   = sh_q;
      byte_d = byte_q;
      push_d = 1'b0;
      master_act = (mode_q == cfgpm_pkg::MODE_MASTER) &&
                   ((st_q == cfgpm_pkg::ST_CMD) || (st_q == cfgpm_pkg::ST_LOAD));
      edge_due = (div_q == HALF_LAST);
      stall    = (st_q == cfgpm_pkg::ST_LOAD) && !sck_q && (bit_q == 6'h00) && !buf_in.ready;
      got_bit  = 1'b0;
      bit_in   = 1'b0;
      unique case (st_q)
         cfgpm_pkg::ST_IDLE: begin
            if (crst_s) begin
               st_d = cfgpm_pkg::ST_SAMPLE;
            end
         end
         cfgpm_pkg::ST_SAMPLE: begin
            mode_d = ss_s ? cfgpm_pkg::MODE_MASTER : cfgpm_pkg::MODE_PERIPH; // RULE2 RULE4 RULE15
            bit_d  = 6'h00;
            byte_d = 8'h00;
            wait_d = '0;
            div_d  = 4'h0;
            sck_d  = 1'b0;
            tx_d   = {cfgpm_pkg::FLASH_READ_CMD, 24'h000000};
            if (multi_image_boot) begin
               tx_d[cfgpm_pkg::IMAGE_SEL_LSB +: 2] = bsel_s; // RULE10
            end
            st_d = ss_s ? cfgpm_pkg::ST_WAIT : cfgpm_pkg::ST_LOAD;
         end
         cfgpm_pkg::ST_WAIT: begin
            if (wait_q == WAIT_LAST) begin // RULE14
               st_d = cfgpm_pkg::ST_CMD;
            end else begin
               wait_d = wait_q + 1'b1;
            end
         end
         cfgpm_pkg::ST_CMD, cfgpm_pkg::ST_LOAD: begin
            if (mode_q == cfgpm_pkg::MODE_MASTER) begin
               // Divider toggles the generated clock; stall holds it low
               if (!stall) begin
                  div_d = edge_due ? 4'h0 : div_q + 1'b1;
               end
               if (edge_due && !stall) begin
                  sck_d = !sck_q; // RULE7
                  if (!sck_q) begin
                     got_bit = (st_q == cfgpm_pkg::ST_LOAD);
                     bit_in  = sd2_s; // RULE9
                     if (st_q == cfgpm_pkg::ST_CMD) begin
                        bit_d = bit_q + 1'b1;
                        if (bit_q == 6'(cfgpm_pkg::HDR_BITS - 1)) begin
                           st_d  = cfgpm_pkg::ST_LOAD;
                           bit_d = 6'h00;
                        end
                     end
                  end else begin
                     tx_d = {tx_q[cfgpm_pkg::HDR_BITS-2:0], 1'b0}; // RULE8
                  end
               end
            end else if (!ss_s && sck_rise) begin
               got_bit = 1'b1; // RULE6
               bit_in  = sd1_s; // RULE8
            end
            if (got_bit) begin
               sh_d  = {sh_q[6:0], bit_in};
               bit_d = bit_q + 1'b1;
               if (bit_q == 6'h07) begin
                  bit_d  = 6'h00;
                  push_d = 1'b1;
                  byte_d = byte_q + 1'b1;
                  if (byte_q == LAST_BYTE) begin
                     st_d  = cfgpm_pkg::ST_DONE;
                     sck_d = 1'b0;
                  end
               end
            end
         end
         cfgpm_pkg::ST_DONE: begin
            st_d = cfgpm_pkg::ST_DONE;
         end
         default: begin
            st_d = cfgpm_pkg::ST_IDLE;
         end
      endcase
      if (!crst_s) begin
         st_d = cfgpm_pkg::ST_IDLE; // RULE1
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q   <= cfgpm_pkg::ST_IDLE;
         mode_q <= cfgpm_pkg::MODE_PERIPH;
         wait_q <= '0;
         div_q  <= 4'h0;
         sck_q  <= 1'b0;
         tx_q   <= '0;
         bit_q  <= 6'h00;
         sh_q   <= 8'h00;
         byte_q <= 8'h00;
         push_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         mode_q <= mode_d;
         wait_q <= wait_d;
         div_q  <= div_d;
         sck_q  <= sck_d;
         tx_q   <= tx_d;
         bit_q  <= bit_d;
         sh_q   <= sh_d;
         byte_q <= byte_d;
         push_q <= push_d;
      end
   end

   // ----------------------------------------
   // Pin directions and values
   // ----------------------------------------
   logic master_run, periph_run, done;
   assign master_run = (mode_q == cfgpm_pkg::MODE_MASTER) &&
                       ((st_q == cfgpm_pkg::ST_WAIT) || master_act);
   assign periph_run = (mode_q == cfgpm_pkg::MODE_PERIPH) && (st_q == cfgpm_pkg::ST_LOAD);
   assign done       = (st_q == cfgpm_pkg::ST_DONE);

   assign ss_n_oe = master_run; // RULE3 RULE4 RULE5
   assign ss_n_o  = !master_act; // RULE5
   assign sck_oe  = master_run; // RULE6 RULE7
   assign sck_o   = sck_q;
   assign sd1_oe  = master_run; // RULE8
   assign sd1_o   = tx_q[cfgpm_pkg::HDR_BITS-1];
   assign sd2_oe  = periph_run; // RULE9
   assign sd2_o   = sh_q[7];

   // Boot select pins fall back to user I/O
   assign boot_image_select_oe = multi_image_boot ? 2'h0 : user_bsel_oe; // RULE11
   assign boot_image_select_o  = user_bsel_o;
   assign user_bsel_i          = bsel_s;

   // Done pin: held low until done, then released or user-driven
   logic user_done;
   assign user_done          = SMALL_PKG && done && user_done_en; // RULE13
   assign config_complete_oe = user_done ? !user_done_val : !done; // RULE12
   assign config_complete_o  = 1'b0;
   assign config_complete    = done;
   assign master_mode        = (mode_q == cfgpm_pkg::MODE_MASTER);

   // ----------------------------------------
   // Receive buffer
   // ----------------------------------------
   assign buf_in.valid = push_q;
   assign buf_in.data  = sh_q;

   cfgpm_buf #(.W(8), .DEPTH(2)) u_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .fill      (buf_in),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_RESET_IDLE : assert property (@(posedge clk) disable iff (!rst_n) // RULE1
      !crst_s |=> (st_q == cfgpm_pkg::ST_IDLE))
      else $error("reset pin low did not return to idle");
   AST_SAMPLE_INPUT : assert property (@(posedge clk) disable iff (!rst_n) // RULE3
      (st_q == cfgpm_pkg::ST_SAMPLE) |-> !ss_n_oe)
      else $error("select driven while sampled");
   AST_MODE_FROM_PIN : assert property (@(posedge clk) disable iff (!rst_n) // RULE2
      (st_q == cfgpm_pkg::ST_SAMPLE) |=> (master_mode == $past(ss_s)))
      else $error("mode does not follow sampled select");
   AST_PERIPH_INPUTS : assert property (@(posedge clk) disable iff (!rst_n) // RULE4
      (st_q == cfgpm_pkg::ST_LOAD) && !master_mode |-> !ss_n_oe && !sck_oe && !sd1_oe && sd2_oe)
      else $error("peripheral mode pin direction wrong");
   AST_MASTER_SELECT : assert property (@(posedge clk) disable iff (!rst_n) // RULE5
      master_mode && (st_q == cfgpm_pkg::ST_CMD) |-> ss_n_oe && !ss_n_o && sck_oe && !sd2_oe)
      else $error("master mode not selecting flash");
   AST_SCK_PERIOD : assert property (@(posedge clk) disable iff (!rst_n) // RULE7
      master_mode && (st_q == cfgpm_pkg::ST_CMD) && $rose(sck_o) |=> sck_o [*3] ##1 !sck_o)
      else $error("generated clock high phase wrong");
   AST_WAIT_BEFORE_CLOCK : assert property (@(posedge clk) disable iff (!rst_n) // RULE14
      $rose(sck_q) |-> (wait_q == WAIT_LAST))
      else $error("clock before power-up wait elapsed");
   AST_MODE_HELD : assert property (@(posedge clk) disable iff (!rst_n) // RULE15
      (st_q != cfgpm_pkg::ST_IDLE) && (st_q != cfgpm_pkg::ST_SAMPLE) && crst_s |=> $stable(mode_q))
      else $error("mode changed during configuration");
   AST_IMAGE_SEL : assert property (@(posedge clk) disable iff (!rst_n) // RULE10
      (st_q == cfgpm_pkg::ST_SAMPLE) && multi_image_boot
      |=> (tx_q[cfgpm_pkg::IMAGE_SEL_LSB +: 2] == $past(bsel_s)))
      else $error("image select not loaded into read address");
   AST_DONE_RELEASE : assert property (@(posedge clk) disable iff (!rst_n) // RULE12
      done && !user_done |-> !config_complete_oe)
      else $error("done pin still pulled low after completion");
   AST_BSEL_GPIO : assert property (@(posedge clk) disable iff (!rst_n) // RULE11
      multi_image_boot |-> (boot_image_select_oe == 2'h0))
      else $error("image select pins driven in multi-image boot");
   AST_DONE_USER : assert property (@(posedge clk) disable iff (!rst_n) // RULE13
      !done |-> config_complete_oe)
      else $error("done pin released before completion");
endmodule

// ### design/cfgpm_pkg.sv
// Constants and types for the configuration pin and mode controller.
// Assumes a 50 MHz system clock; no other package is needed.
package cfgpm_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS  = 20;
   localparam int WAIT_SMALL_US  = 800;
   localparam int WAIT_LARGE_US  = 1200;
   localparam int WAIT_SMALL_CYC = (WAIT_SMALL_US * 1000) / CLK_PERIOD_NS;
   localparam int WAIT_LARGE_CYC = (WAIT_LARGE_US * 1000) / CLK_PERIOD_NS;
   localparam int LINK_PERIOD_NS = 160;
   localparam int SCK_HALF_CYC   = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int WAIT_W         = 17;

   // ----------------------------------------
   // Flash read header layout
   // ----------------------------------------
   localparam logic [7:0] FLASH_READ_CMD = 8'h03;
   localparam int         HDR_BITS       = 32;
   localparam int         IMAGE_SEL_LSB  = 16;
   localparam int         LOAD_BYTES     = 16;

   // ----------------------------------------
   // Sampled pin vector positions
   // ----------------------------------------
   localparam int PIN_CRST = 0;
   localparam int PIN_SS   = 1;
   localparam int PIN_SCK  = 2;
   localparam int PIN_SI   = 3;
   localparam int PIN_SO   = 4;
   localparam int PIN_BSEL = 5;
   localparam int PIN_W    = 7;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_SAMPLE = 3'h1,
      ST_WAIT   = 3'h2,
      ST_CMD    = 3'h3,
      ST_LOAD   = 3'h4,
      ST_DONE   = 3'h5
   } cfgpm_state_type;

   typedef enum logic {
      MODE_PERIPH = 1'b0,
      MODE_MASTER = 1'b1
   } cfgpm_mode_type;

endpackage

// ### design/cfgpm_stream_if.sv
// Byte stream carrier between the controller and its buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface cfgpm_stream_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ### design/cfgpm_buf.sv
// Small valid/ready buffer for received configuration bytes.
// Assumes one clock, asynchronous active-low reset; DEPTH a power of two.
`timescale 1ns/1ns
module cfgpm_buf #(
   parameter int W     = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Fill side
   cfgpm_stream_if.snk       fill,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0] mem_q [DEPTH];
   logic [W-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          push, pop;

   // ----------------------------------------
   // Pointer and storage update
   // ----------------------------------------
   always_comb begin
      push = fill.valid && (cnt_q != (AW+1)'(DEPTH));
      pop  = out_ready && (cnt_q != '0);
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = fill.data;
         wr_d        = wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = rd_q + 1'b1;
      end
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Honest full and empty
   assign fill.ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid  = (cnt_q != '0);
   assign out_data   = mem_q[rd_q];

   AST_BUF_NO_OVERFLOW : assert property (@(posedge clk) disable iff (!rst_n)
      cnt_q <= (AW+1)'(DEPTH))
      else $error("buffer count above depth");
endmodule

// ### bench/cfgpm_far_model.sv
// Far-side partner: serial flash when the device is master, configuring host otherwise.
// Assumes the bench resolves each pin from the design's enable, else this model's drive, and feeds sck and ss_n back here.
`timescale 1ns/1ns
module cfgpm_far_model #(
   parameter int NBYTES = 4
) (
   // Role select
   input  wire logic   host_mode,
   // Resolved pins
   input  wire logic   sck,
   input  wire logic   ss_n,
   // Own drives
   output logic        m_sck,
   output logic        m_ss_en,
   output logic        m_sd1,
   output logic        m_sd2,
   // Flash observation
   output logic [31:0] hdr,
   output int          rises
);
   logic       sel;
   logic [7:0] cur;

   // Flash answers only while selected and not in host role
   assign sel = !host_mode && (ss_n === 1'b0);

   initial begin
      m_sck   = 1'b0;
      m_ss_en = 1'b0;
      m_sd1   = 1'b0;
      m_sd2   = 1'b0;
      hdr     = 32'h0;
      rises   = 0;
   end

   // Flash header shift-in on rising clock
   always @(posedge sck) begin
      if (sel) begin
         if (rises < 32) hdr = {hdr[30:0], m_sd1_in()};
         rises = rises + 1;
      end
   end

   function automatic logic m_sd1_in();
      return test_config_pin_mode_control.sd1_pin;
   endfunction

   // Flash data out on falling clock, MSB first; released line shows the inverse
   always @(negedge sck) begin
      if (sel && rises >= 32 && rises < 32 + 8 * NBYTES) begin
         cur   = image_byte((rises - 32) / 8);
         m_sd2 = cur[7 - (rises - 32) % 8];
      end else begin
         m_sd2 = ~m_sd2;
      end
   end

   // Deselect restarts the flash command
   always @(posedge ss_n) begin
      rises = 0;
      m_sd2 = ~m_sd2;
   end

   function automatic logic [7:0] image_byte(input int k);
      return 8'hA5 ^ (8'(k) * 8'h11);
   endfunction

   // Host select control; phase offset keeps the link clock unrelated to clk
   task automatic host_select(input logic on);
      #7;
      m_ss_en = on;
      if (!on) m_sd1 = ~m_sd1;
   endtask

   // Host byte, MSB first, 160 ns link clock only within frames
   task automatic host_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         m_sd1 = b[i];
         #80 m_sck = 1'b1;
         #80 m_sck = 1'b0;
      end
   endtask
endmodule

// ### bench/test_config_pin_mode_control.sv
// Self-checking bench for the configuration pin and mode controller.
// Assumes the far-side model and the design files are compiled first.
`timescale 1ns/1ns
module test_config_pin_mode_control;
   localparam int WS = 20;
   localparam int NB = 4;

   logic       clk, rst_n, config_reset_n, multi_image_boot, rx_ready, host_mode;
   logic       user_done_en, user_done_val, sck_o, sck_oe, ss_n_o, ss_n_oe;
   logic       sd1_o, sd1_oe, sd2_o, sd2_oe, config_complete_o, config_complete_oe;
   logic       config_complete, master_mode, rx_valid, m_sck, m_ss_en, m_sd1, m_sd2;
   logic       sck_pin, ss_pin, sd1_pin, sd2_pin;
   logic [1:0] user_bsel_o, user_bsel_oe, user_bsel_i, bsel_drv, bsel_pin;
   logic [1:0] boot_image_select_o, boot_image_select_oe;
   logic [7:0] rx_data;
   logic [31:0] hdr;
   int         rises, n_errors, checks;

   // Pin resolution; select pin has a pull-up
   assign sck_pin  = sck_oe ? sck_o : m_sck;
   assign ss_pin   = ss_n_oe ? ss_n_o : !m_ss_en;
   assign sd1_pin  = sd1_oe ? sd1_o : m_sd1;
   assign sd2_pin  = sd2_oe ? sd2_o : m_sd2;
   assign bsel_pin = (boot_image_select_oe & boot_image_select_o)
                   | (~boot_image_select_oe & bsel_drv);

   cfgpm_top #(.LOAD_BYTES(NB), .SMALL_PKG(1'b1), .WAIT_SMALL(WS), .WAIT_LARGE(30)) dut (
      .clk(clk), .rst_n(rst_n), .config_reset_n(config_reset_n),
      .sck_i(sck_pin), .sck_o(sck_o), .sck_oe(sck_oe),
      .ss_n_i(ss_pin), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe),
      .sd1_i(sd1_pin), .sd1_o(sd1_o), .sd1_oe(sd1_oe),
      .sd2_i(sd2_pin), .sd2_o(sd2_o), .sd2_oe(sd2_oe),
      .boot_image_select_i(bsel_pin), .boot_image_select_o(boot_image_select_o),
      .boot_image_select_oe(boot_image_select_oe), .multi_image_boot(multi_image_boot),
      .user_bsel_o(user_bsel_o), .user_bsel_oe(user_bsel_oe), .user_bsel_i(user_bsel_i),
      .user_done_en(user_done_en), .user_done_val(user_done_val),
      .config_complete_o(config_complete_o), .config_complete_oe(config_complete_oe),
      .config_complete(config_complete), .master_mode(master_mode),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));

   cfgpm_far_model #(.NBYTES(NB)) far (
      .host_mode(host_mode), .sck(sck_pin), .ss_n(ss_pin), .m_sck(m_sck),
      .m_ss_en(m_ss_en), .m_sd1(m_sd1), .m_sd2(m_sd2), .hdr(hdr), .rises(rises));

   // Clock
   always #10 clk = ~clk;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   function automatic logic pick(input int which);
      case (which)
         0: return rx_valid;
         1: return config_complete;
         default: return sck_o;
      endcase
   endfunction

   // Bounded wait for a design output, counted in cycles
   task automatic wait_sig(input int which, input int bound, output int n);
      n = 0;
      while (n < bound && pick(which) !== 1'b1) begin
         @(negedge clk);
         n++;
      end
      if (n >= bound) begin
         n_errors++;
         $display("BAD wait %0d expected high seen timeout", which);
         test_done();
      end
   endtask

   // Collect bytes with ready held high; a pop lands on the next rising edge
   task automatic get_bytes(input int n);
      int got;
      int t;
      got = 0;
      t = 0;
      while (got < n && t < 8000) begin
         @(negedge clk);
         t++;
         if (rx_valid === 1'b1) begin
            chk("rx_data", 32'(rx_data), 32'(far.image_byte(got)));
            got++;
         end
      end
      if (got < n) begin
         n_errors++;
         $display("BAD rx_count expected %0d seen %0d", n, got);
         test_done();
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_held();
      @(negedge clk);
      chk("held_sck_oe", 32'(sck_oe), 32'h0);
      chk("held_ss_oe", 32'(ss_n_oe), 32'h0);
      chk("held_done_oe", 32'(config_complete_oe), 32'h1);
      chk("held_done", 32'(config_complete), 32'h0);
      chk("held_done_o", 32'(config_complete_o), 32'h0);
   endtask

   task automatic t_bsel();
      @(posedge clk);
      multi_image_boot <= 1'b0;
      user_bsel_oe     <= 2'h1;
      user_bsel_o      <= 2'h1;
      bsel_drv         <= 2'h2;
      cyc(5);
      @(negedge clk);
      chk("bsel_oe", 32'(boot_image_select_oe), 32'h1);
      chk("bsel_in", 32'(user_bsel_i), 32'h3);
      @(posedge clk);
      multi_image_boot <= ~multi_image_boot;
      cyc(2);
      @(negedge clk);
      chk("bsel_oe_boot", 32'(boot_image_select_oe), 32'h0);
   endtask

   task automatic t_master();
      int n;
      int r;
      @(posedge clk);
      host_mode      <= 1'b0;
      rx_ready       <= ~rx_ready;
      config_reset_n <= 1'b1;
      cyc(8);
      @(negedge clk);
      chk("m_mode", 32'(master_mode), 32'h1);
      chk("m_ss_oe", 32'(ss_n_oe), 32'h1);
      chk("m_sck_oe", 32'(sck_oe), 32'h1);
      chk("m_sd1_oe", 32'(sd1_oe), 32'h1);
      chk("m_sd2_oe", 32'(sd2_oe), 32'h0);
      wait_sig(2, 400, n);
      chk("m_wait_ok", 32'(n + 8 >= WS), 32'h1);
      chk("m_ss_low", 32'(ss_n_o), 32'h0);
      wait_sig(0, 4000, n);
      cyc(300);
      r = rises;
      cyc(200);
      chk("m_stall", 32'(rises), 32'(r));
      chk("m_hdr", hdr, 32'h0302_0000);
      @(posedge clk);
      rx_ready <= ~rx_ready;
      get_bytes(NB);
      wait_sig(1, 2000, n);
      chk("m_done_oe", 32'(config_complete_oe), 32'h0);
      chk("m_mode_kept", 32'(master_mode), 32'h1);
      @(posedge clk);
      user_done_en  <= ~user_done_en;
      user_done_val <= ~user_done_val;
      cyc(3);
      @(negedge clk);
      chk("user_done_lo", 32'(config_complete_oe), 32'h1);
      @(posedge clk);
      user_done_val <= ~user_done_val;
      cyc(3);
      @(negedge clk);
      chk("user_done_hi", 32'(config_complete_oe), 32'h0);
      @(posedge clk);
      user_done_en <= ~user_done_en;
   endtask

   task automatic t_abort();
      @(posedge clk);
      config_reset_n <= 1'b0;
      cyc(6);
      @(negedge clk);
      chk("ab_done", 32'(config_complete), 32'h0);
      @(posedge clk);
      config_reset_n <= 1'b1;
      cyc(10);
      config_reset_n <= 1'b0;
      cyc(5);
      @(negedge clk);
      chk("ab_ss_oe", 32'(ss_n_oe), 32'h0);
      chk("ab_sck_oe", 32'(sck_oe), 32'h0);
      chk("ab_done_oe", 32'(config_complete_oe), 32'h1);
   endtask

   task automatic t_periph();
      int n;
      @(posedge clk);
      host_mode <= 1'b1;
      far.host_select(1'b1);
      cyc(3);
      config_reset_n <= 1'b1;
      cyc(8);
      @(negedge clk);
      chk("p_mode", 32'(master_mode), 32'h0);
      chk("p_ss_oe", 32'(ss_n_oe), 32'h0);
      chk("p_sck_oe", 32'(sck_oe), 32'h0);
      chk("p_sd1_oe", 32'(sd1_oe), 32'h0);
      fork
         begin
            far.host_byte(far.image_byte(0));
            chk("p_sd2_oe", 32'(sd2_oe), 32'h1);
            chk("p_sd2_o", 32'(sd2_o), 32'(far.image_byte(0) >> 7));
            far.host_byte(far.image_byte(1));
            far.host_select(1'b0);
            #800;
            chk("p_mode_kept", 32'(master_mode), 32'h0);
            far.host_select(1'b1);
            far.host_byte(far.image_byte(2));
            far.host_byte(far.image_byte(3));
         end
         get_bytes(NB);
      join
      wait_sig(1, 200, n);
      chk("p_done_oe", 32'(config_complete_oe), 32'h0);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      config_reset_n = 1'b0;
      multi_image_boot = 1'b0;
      rx_ready = 1'b1;
      host_mode = 1'b0;
      user_done_en = 1'b0;
      user_done_val = 1'b1;
      user_bsel_o = 2'h0;
      user_bsel_oe = 2'h0;
      bsel_drv = 2'h0;
      n_errors = 0;
      checks = 0;
      cyc(20);
      rst_n <= 1'b1;
      cyc(4);
      t_held();
      t_bsel();
      t_master();
      t_abort();
      t_periph();
      test_done();
   end
endmodule
